// ==== hw/rtcev_alarm.sv ====
// Alarm comparator: each enabled alarm byte against its running time byte.
// Assumes alarm bytes ordered sec, min, hour, date, month, weekday.
`timescale 1ns/1ns
module rtcev_alarm (
  input  wire logic [5:0][7:0]         alarm_i,
  input  wire rtcev_pkg::rtcev_time_t  time_i,
  output logic                         match_o
);

  logic [5:0][7:0] cur;
  logic            any_en;
  logic            all_eq;

  assign cur = {time_i.dow, time_i.month, time_i.date, time_i.hour, time_i.min, time_i.sec};

  // Bit 7 is the compare enable; no year byte exists
  always_comb begin
    any_en = 1'b0;
    all_eq = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (alarm_i[i][7]) begin
        any_en = 1'b1;
        if (alarm_i[i][6:0] != cur[i][6:0]) begin
          all_eq = 1'b0;
        end
      end
    end
  end

  assign match_o = any_en && all_eq;

endmodule

// ==== hw/rtcev_debounce.sv ====
// Event input hysteresis filter with four selectable hold times.
// Assumes the input is already synchronised to sys_clk_i.
`timescale 1ns/1ns
module rtcev_debounce #(
  parameter int CNT_W = 21,
  parameter int CYC1  = rtcev_pkg::DEB1_CYC,
  parameter int CYC2  = rtcev_pkg::DEB2_CYC,
  parameter int CYC3  = rtcev_pkg::DEB3_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       raw_i,
  output logic            filt_o
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             filt_ff;
  logic             nxt_filt;
  logic [CNT_W-1:0] hold;

  always_comb begin
    case (sel_i)
      2'h1:    hold = CNT_W'(CYC1);
      2'h2:    hold = CNT_W'(CYC2);
      2'h3:    hold = CNT_W'(CYC3);
      default: hold = '0;
    endcase
  end

  // New level accepted only once stable for the whole hold time
  always_comb begin
    nxt_cnt  = '0;
    nxt_filt = filt_ff;
    if (raw_i == filt_ff) begin
      nxt_cnt = '0;
    end else if (sel_i == 2'h0 || cnt_ff >= hold - CNT_W'(1)) begin
      nxt_filt = raw_i;
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end

  assign filt_o = filt_ff;

endmodule

// ==== hw/rtcev_pkg.sv ====
// Shared constants and types of the event, alarm and trim control block.
// Assumes a 50 MHz system clock and a byte-wide register port from the serial engine.
package rtcev_pkg;

  // Register offsets
  localparam logic [4:0] ADDR_SEC     = 5'h00;
  localparam logic [4:0] ADDR_DOW     = 5'h06;
  localparam logic [4:0] ADDR_STATUS  = 5'h07;
  localparam logic [4:0] ADDR_INTCTL  = 5'h08;
  localparam logic [4:0] ADDR_EVCFG   = 5'h09;
  localparam logic [4:0] ADDR_ATRIM   = 5'h0A;
  localparam logic [4:0] ADDR_DTRIM   = 5'h0B;
  localparam logic [4:0] ADDR_ALM_LO  = 5'h0C;
  localparam logic [4:0] ADDR_ALM_HI  = 5'h11;
  localparam logic [4:0] ADDR_TS_LO   = 5'h14;
  localparam logic [4:0] ADDR_TS_HI   = 5'h19;

  // Status register fields
  localparam int ST_AUTO_CLR_BIT = 7;
  localparam int ST_EVT_BIT      = 3;
  localparam int ST_ALM_BIT      = 2;

  // Interrupt control fields
  localparam int IC_PULSE_BIT = 7;
  localparam int IC_ALARM_ENABLE_BIT  = 6;
  localparam int IC_FO_MSB    = 3;

  // Event configuration fields
  localparam int EV_EN_BIT     = 7;
  localparam int EV_HALT_BIT   = 6;
  localparam int EV_DEB_LSB    = 4;
  localparam int EV_SMP_LSB    = 2;
  localparam int EV_BATDIS_BIT = 1;
  localparam int EV_PUDIS_BIT  = 0;

  // Trim fields
  localparam int AT_OFS_LSB  = 6;
  localparam int DT_SIGN_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic [7:0] RST_EVCFG  = 8'h00;
  localparam logic [7:0] RST_ATRIM  = 8'h00;
  localparam logic [7:0] RST_DTRIM  = 8'h00;
  localparam logic [7:0] RST_ALARM  = 8'h00;

  // Timing
  localparam int CLK_MHZ      = 50;
  localparam int DEB1_US      = 3900;
  localparam int DEB2_US      = 15625;
  localparam int DEB3_US      = 31250;
  localparam int PULSE_US     = 250000;
  localparam int DEB1_CYC     = DEB1_US * CLK_MHZ;
  localparam int DEB2_CYC     = DEB2_US * CLK_MHZ;
  localparam int DEB3_CYC     = DEB3_US * CLK_MHZ;
  localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int TB_PER_SEC   = 32768;
  localparam int PPM_STEP     = 20;
  localparam int PPM_UNITY    = 1000000;
  localparam int TRIM_INC     = PPM_STEP * TB_PER_SEC;

  // Load capacitance in quarter picofarads
  localparam logic [6:0] CLOAD_BASE_QPF = 7'h12;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] dow;
  } rtcev_time_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rtcev_req_t;

endpackage

// ==== hw/rtcev_top.sv ====
// Event detect, halt, alarm and oscillator trim control of the real-time clock.
// Assumes a serial engine issues one-cycle register strobes and the time counter
// advances its fields on sec_tick_o, showing the new time one cycle later.
//
// Behaviour
// - Event input filtered by hysteresis 0, 3.9, 15.625 or 31.25 ms.
// - Event enable bit gates event detection and time-stamp capture.
// - Only the first event is stamped until the event flag clears.
// - Halt-on-event with a detected event stops clock counting.
// - A time write resumes counting and, only while halted, clears halt-on-event.
// - Halt has effect only while event detection is enabled.
// - In battery mode the event output is suppressed if disabled.
// - Pull-up disable bit turns the event input pull-up off.
// - Six-bit analog trim sets load capacitance, top bit inverted weight.
// - Battery mode adds -0.5, +0.5 or +1 pF capacitance offset.
// - Digital trim top bit is sign, lower bits weigh 40 and 20 ppm.
// - Digital trim adjusts average ticks per second, up to 60 ppm.
// - Alarm bytes match time bytes, bit 7 is compare enable.
// - Alarm triggers when at least one field is enabled and every enabled field equals the time.
// - Single mode sets alarm flag, interrupt held low until cleared.
// - Repeating mode pulses interrupt on every match indefinitely.
// - Writing 0 clears alarm flag; auto-clear clears it on status read.
// - Repeating mode sets flag each trigger, pulses regardless of flag.
// - Repeating alarm pulse is active low, 250 ms long.
// - An event sets flag, pulls event output low, stamps time.
`timescale 1ns/1ns
module rtcev_top #(
  parameter int DEB1_CYC  = rtcev_pkg::DEB1_CYC,
  parameter int DEB2_CYC  = rtcev_pkg::DEB2_CYC,
  parameter int DEB3_CYC  = rtcev_pkg::DEB3_CYC,
  parameter int PULSE_CYC = rtcev_pkg::PULSE_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire rtcev_pkg::rtcev_req_t  req_i,
  output logic [7:0]                  rdata_o,
  input  wire rtcev_pkg::rtcev_time_t time_i,
  input  wire logic                   time_write_i,
  input  wire logic                   ts_tick_i,
  output logic                        sec_tick_o,
  output logic                        count_halt_o,
  input  wire logic                   event_input_i,
  input  wire logic                   battery_mode_i,
  output logic                        irq_o,
  output logic                        irq_oe_o,
  output logic                        event_pullup_en_o,
  output logic [6:0]                  cload_qpf_o
);

  localparam int ACC_W = 22;
  localparam int TBC_W = 16;

  // Quarter-pF load capacitance from the analog trim code
  function automatic logic [6:0] cload_of(input logic [5:0] code, input logic [1:0] ofs, input logic bat);
    logic [6:0] c;
    c = rtcev_pkg::CLOAD_BASE_QPF + {1'b0, ~code[5], code[4:0]};
    if (bat) begin
      case (ofs)
        2'h1:    c = c - 7'h02;
        2'h2:    c = c + 7'h02;
        2'h3:    c = c + 7'h04;
        default: c = c;
      endcase
    end
    return c;
  endfunction

  // Register state
  logic [7:0]      intctl_ff, nxt_intctl;
  logic [7:0]      evcfg_ff, nxt_evcfg;
  logic [7:0]      atrim_ff, nxt_atrim;
  logic [2:0]      dtrim_ff, nxt_dtrim;
  logic            auto_clr_ff, nxt_auto_clr;
  logic            evt_flag_ff, nxt_evt_flag;
  logic            alm_flag_ff, nxt_alm_flag;
  logic            halt_ff, nxt_halt;
  logic [5:0][7:0] alarm_ff, nxt_alarm;
  logic [5:0][7:0] stamp_ff, nxt_stamp;
  logic [7:0]      rdata_ff, nxt_rdata;

  // Pin synchronisers and event edge
  logic [1:0] ev_sync_ff;
  logic [1:0] bat_sync_ff;
  logic       ev_filt;
  logic       ev_prev_ff;
  logic       ev_hit;

  // Seconds generation
  logic [TBC_W-1:0] tb_cnt_ff, nxt_tb_cnt;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic [1:0]       corr_ff, nxt_corr;
  logic             sec_ff, nxt_sec;
  logic             eval_ff;
  logic [TBC_W-1:0] sec_len;

  // Alarm and output pin
  logic        match;
  logic        alarm_on;
  logic        pulse_mode;
  logic        alm_hit;
  logic [23:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic        irq_oe_ff, nxt_irq_oe;
  logic        pu_en_ff;
  logic [6:0]  cload_ff;

  logic ev_en;
  logic st_wr;
  logic st_rd_clr;

  assign ev_en      = evcfg_ff[rtcev_pkg::EV_EN_BIT];
  assign pulse_mode = intctl_ff[rtcev_pkg::IC_PULSE_BIT];
  assign alarm_on   = intctl_ff[rtcev_pkg::IC_ALARM_ENABLE_BIT] && (intctl_ff[rtcev_pkg::IC_FO_MSB:0] == 4'h0);
  assign st_wr      = req_i.wr && req_i.addr == rtcev_pkg::ADDR_STATUS;
  assign st_rd_clr  = req_i.rd && req_i.addr == rtcev_pkg::ADDR_STATUS && auto_clr_ff;

  rtcev_debounce #(
    .CNT_W (21),
    .CYC1  (DEB1_CYC),
    .CYC2  (DEB2_CYC),
    .CYC3  (DEB3_CYC)
  ) u_deb (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (evcfg_ff[rtcev_pkg::EV_DEB_LSB +: 2]),
    .raw_i     (ev_sync_ff[1]),
    .filt_o    (ev_filt)
  );

  rtcev_alarm u_alm (
    .alarm_i (alarm_ff),
    .time_i  (time_i),
    .match_o (match)
  );

  // Low-to-high transition of the filtered input, only while enabled
  assign ev_hit  = ev_en && ev_filt && !ev_prev_ff;
  assign alm_hit = eval_ff && alarm_on && match;

  // Register file and flags
  always_comb begin
    nxt_intctl   = intctl_ff;
    nxt_evcfg    = evcfg_ff;
    nxt_atrim    = atrim_ff;
    nxt_dtrim    = dtrim_ff;
    nxt_auto_clr = auto_clr_ff;
    nxt_alarm    = alarm_ff;
    nxt_stamp    = stamp_ff;
    nxt_evt_flag = evt_flag_ff;
    nxt_alm_flag = alm_flag_ff;
    nxt_halt     = halt_ff;
    if (req_i.wr) begin
      case (req_i.addr)
        rtcev_pkg::ADDR_INTCTL: nxt_intctl = req_i.wdata;
        rtcev_pkg::ADDR_EVCFG:  nxt_evcfg  = req_i.wdata;
        rtcev_pkg::ADDR_ATRIM:  nxt_atrim  = req_i.wdata;
        rtcev_pkg::ADDR_DTRIM:  nxt_dtrim  = req_i.wdata[2:0];
        rtcev_pkg::ADDR_STATUS: nxt_auto_clr = req_i.wdata[rtcev_pkg::ST_AUTO_CLR_BIT];
        default: begin
          if (req_i.addr >= rtcev_pkg::ADDR_ALM_LO && req_i.addr <= rtcev_pkg::ADDR_ALM_HI) begin
            nxt_alarm[3'(req_i.addr - rtcev_pkg::ADDR_ALM_LO)] = req_i.wdata;
          end
        end
      endcase
    end
    // Flags: a write of 0 or an auto-clearing read clears, never sets
    if ((st_wr && !req_i.wdata[rtcev_pkg::ST_EVT_BIT]) || st_rd_clr) begin
      nxt_evt_flag = 1'b0;
    end
    if ((st_wr && !req_i.wdata[rtcev_pkg::ST_ALM_BIT]) || st_rd_clr) begin
      nxt_alm_flag = 1'b0;
    end
    // Flag set wins over a same-cycle clear; a time write or detection off wins over a same-cycle halt set
    if (ev_hit) begin
      nxt_evt_flag = 1'b1;
      if (!evt_flag_ff) begin
        nxt_stamp = {time_i.year, time_i.month, time_i.date, time_i.hour, time_i.min, time_i.sec};
      end
      if (evcfg_ff[rtcev_pkg::EV_HALT_BIT]) begin
        nxt_halt = 1'b1;
      end
    end
    if (alm_hit) begin
      nxt_alm_flag = 1'b1;
    end
    if (time_write_i) begin
      nxt_halt = 1'b0;
      if (halt_ff) begin
        nxt_evcfg[rtcev_pkg::EV_HALT_BIT] = 1'b0;
      end
    end
    if (!ev_en) begin
      nxt_halt = 1'b0;
    end
  end

  // Read data, one cycle after the read strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req_i.rd) begin
      case (req_i.addr)
        rtcev_pkg::ADDR_STATUS: begin
          nxt_rdata = 8'h00;
          nxt_rdata[rtcev_pkg::ST_AUTO_CLR_BIT] = auto_clr_ff;
          nxt_rdata[rtcev_pkg::ST_EVT_BIT]      = evt_flag_ff;
          nxt_rdata[rtcev_pkg::ST_ALM_BIT]      = alm_flag_ff;
        end
        rtcev_pkg::ADDR_INTCTL: nxt_rdata = intctl_ff;
        rtcev_pkg::ADDR_EVCFG:  nxt_rdata = evcfg_ff;
        rtcev_pkg::ADDR_ATRIM:  nxt_rdata = atrim_ff;
        rtcev_pkg::ADDR_DTRIM:  nxt_rdata = {5'h00, dtrim_ff};
        default: begin
          nxt_rdata = 8'h00;
          if (req_i.addr <= rtcev_pkg::ADDR_DOW) begin
            nxt_rdata = time_i[8*(6 - int'(req_i.addr)) +: 8];
          end else if (req_i.addr >= rtcev_pkg::ADDR_ALM_LO && req_i.addr <= rtcev_pkg::ADDR_ALM_HI) begin
            nxt_rdata = alarm_ff[3'(req_i.addr - rtcev_pkg::ADDR_ALM_LO)];
          end else if (req_i.addr >= rtcev_pkg::ADDR_TS_LO && req_i.addr <= rtcev_pkg::ADDR_TS_HI) begin
            nxt_rdata = stamp_ff[3'(req_i.addr - rtcev_pkg::ADDR_TS_LO)];
          end
        end
      endcase
    end
  end

  // Seconds from time-base ticks with digital trim
  assign sec_len = TBC_W'(rtcev_pkg::TB_PER_SEC) + (dtrim_ff[rtcev_pkg::DT_SIGN_BIT] ? TBC_W'(corr_ff)
                 : -TBC_W'(corr_ff));

  always_comb begin
    logic [ACC_W-1:0] acc;
    acc        = acc_ff;
    nxt_tb_cnt = tb_cnt_ff;
    nxt_acc    = acc_ff;
    nxt_corr   = corr_ff;
    nxt_sec    = 1'b0;
    if (time_write_i || halt_ff) begin
      nxt_tb_cnt = '0;
    end else if (ts_tick_i) begin
      if (tb_cnt_ff >= sec_len - TBC_W'(1)) begin
        nxt_tb_cnt = '0;
        nxt_sec    = 1'b1;
        // Fractional ppm carried from second to second
        acc = acc_ff + ACC_W'(dtrim_ff[1:0]) * ACC_W'(rtcev_pkg::TRIM_INC);
        if (acc >= ACC_W'(2 * rtcev_pkg::PPM_UNITY)) begin
          nxt_corr = 2'h2;
          nxt_acc  = acc - ACC_W'(2 * rtcev_pkg::PPM_UNITY);
        end else if (acc >= ACC_W'(rtcev_pkg::PPM_UNITY)) begin
          nxt_corr = 2'h1;
          nxt_acc  = acc - ACC_W'(rtcev_pkg::PPM_UNITY);
        end else begin
          nxt_corr = 2'h0;
          nxt_acc  = acc;
        end
      end else begin
        nxt_tb_cnt = tb_cnt_ff + TBC_W'(1);
      end
    end
  end

  // Interrupt / event pin, open drain, driven while low
  always_comb begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (alm_hit && pulse_mode) begin
      nxt_pulse_cnt = 24'(PULSE_CYC);
    end else if (pulse_cnt_ff != 24'h000000) begin
      nxt_pulse_cnt = pulse_cnt_ff - 24'h000001;
    end
    nxt_irq_oe = 1'b0;
    if (alarm_on && !pulse_mode && alm_flag_ff) begin
      nxt_irq_oe = 1'b1;
    end
    if (alarm_on && pulse_mode && pulse_cnt_ff != 24'h000000) begin
      nxt_irq_oe = 1'b1;
    end
    if (ev_en && evt_flag_ff && !(bat_sync_ff[1] && evcfg_ff[rtcev_pkg::EV_BATDIS_BIT])) begin
      nxt_irq_oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intctl_ff    <= rtcev_pkg::RST_INTCTL;
      evcfg_ff     <= rtcev_pkg::RST_EVCFG;
      atrim_ff     <= rtcev_pkg::RST_ATRIM;
      dtrim_ff     <= rtcev_pkg::RST_DTRIM[2:0];
      auto_clr_ff  <= rtcev_pkg::RST_STATUS[rtcev_pkg::ST_AUTO_CLR_BIT];
      evt_flag_ff  <= 1'b0;
      alm_flag_ff  <= 1'b0;
      halt_ff      <= 1'b0;
      alarm_ff     <= {6{rtcev_pkg::RST_ALARM}};
      stamp_ff     <= '0;
      rdata_ff     <= 8'h00;
      ev_sync_ff   <= 2'h0;
      bat_sync_ff  <= 2'h0;
      ev_prev_ff   <= 1'b0;
      tb_cnt_ff    <= '0;
      acc_ff       <= '0;
      corr_ff      <= 2'h0;
      sec_ff       <= 1'b0;
      eval_ff      <= 1'b0;
      pulse_cnt_ff <= 24'h000000;
      irq_oe_ff    <= 1'b0;
      pu_en_ff     <= 1'b0;
      cload_ff     <= rtcev_pkg::CLOAD_BASE_QPF;
    end else begin
      intctl_ff    <= nxt_intctl;
      evcfg_ff     <= nxt_evcfg;
      atrim_ff     <= nxt_atrim;
      dtrim_ff     <= nxt_dtrim;
      auto_clr_ff  <= nxt_auto_clr;
      evt_flag_ff  <= nxt_evt_flag;
      alm_flag_ff  <= nxt_alm_flag;
      halt_ff      <= nxt_halt;
      alarm_ff     <= nxt_alarm;
      stamp_ff     <= nxt_stamp;
      rdata_ff     <= nxt_rdata;
      ev_sync_ff   <= {ev_sync_ff[0], event_input_i};
      bat_sync_ff  <= {bat_sync_ff[0], battery_mode_i};
      ev_prev_ff   <= ev_filt;
      tb_cnt_ff    <= nxt_tb_cnt;
      acc_ff       <= nxt_acc;
      corr_ff      <= nxt_corr;
      sec_ff       <= nxt_sec;
      eval_ff      <= sec_ff;
      pulse_cnt_ff <= nxt_pulse_cnt;
      irq_oe_ff    <= nxt_irq_oe;
      pu_en_ff     <= !evcfg_ff[rtcev_pkg::EV_PUDIS_BIT];
      cload_ff     <= cload_of(atrim_ff[5:0], atrim_ff[rtcev_pkg::AT_OFS_LSB +: 2], bat_sync_ff[1]);
    end
  end

  assign rdata_o           = rdata_ff;
  assign sec_tick_o        = sec_ff;
  assign count_halt_o      = halt_ff;
  assign irq_o             = 1'b0;
  assign irq_oe_o          = irq_oe_ff;
  assign event_pullup_en_o = pu_en_ff;
  assign cload_qpf_o       = cload_ff;

endmodule

// ==== tb/rtcev_clock_model.sv ====
// Time counter model beside the block: time base ticks and running time bytes.
// Assumes sec_tick_i is the block's one-cycle second pulse.
`timescale 1ns/1ns
module rtcev_clock_model (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   sec_tick_i,
  input  wire logic                   load_i,
  input  wire rtcev_pkg::rtcev_time_t load_val_i,
  output logic                        ts_tick_o,
  output rtcev_pkg::rtcev_time_t      time_o
);
  rtcev_pkg::rtcev_time_t nxt_time;

  // Only seconds advance; a run never spans a minute
  always_comb begin
    nxt_time = time_o;
    if (load_i) begin
      nxt_time = load_val_i;
    end else if (sec_tick_i) begin
      nxt_time.sec = (time_o.sec[3:0] == 4'h9) ? {time_o.sec[7:4] + 4'h1, 4'h0} : time_o.sec + 8'h01;
    end
  end

  // Tick every clock keeps one second at 32768 clocks
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_o    <= '0;
      ts_tick_o <= 1'b0;
    end else begin
      time_o    <= nxt_time;
      ts_tick_o <= 1'b1;
    end
  end
endmodule

// ==== tb/rtcev_top_sva.sv ====
// Concurrent checks on the ports of the event, alarm and trim control block.
// Assumes it is bound into rtcev_top and sees nothing but that module's ports.
`timescale 1ns/1ns
module rtcev_top_sva (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire rtcev_pkg::rtcev_req_t req_i,
  input  wire logic                  time_write_i,
  input  wire logic                  ts_tick_i,
  input  wire logic                  sec_tick_o,
  input  wire logic                  count_halt_o,
  input  wire logic                  battery_mode_i,
  input  wire logic                  irq_o,
  input  wire logic                  irq_oe_o,
  input  wire logic                  event_pullup_en_o,
  input  wire logic [6:0]            cload_qpf_o
);
  logic [16:0] tick_cnt_ff;
  logic        seen_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Second length only judged between two undisturbed second pulses
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= 17'h00000;
      seen_ff     <= 1'b0;
    end else if (sec_tick_o || time_write_i || count_halt_o) begin
      tick_cnt_ff <= 17'h00000;
      seen_ff     <= sec_tick_o && !time_write_i && !count_halt_o;
    end else if (ts_tick_i) begin
      tick_cnt_ff <= tick_cnt_ff + 17'h00001;
    end
  end

  sequence atrim_wr_s;
    req_i.wr && req_i.addr == rtcev_pkg::ADDR_ATRIM && !battery_mode_i;
  endsequence
  sequence evcfg_wr_s;
    req_i.wr && req_i.addr == rtcev_pkg::ADDR_EVCFG;
  endsequence

  irq_level_a: assert property (irq_o == 1'b0) else $error("irq pin value not low");
  pullup_ctl_a: assert property (evcfg_wr_s |-> ##2 event_pullup_en_o == !$past(req_i.wdata[0], 2))
    else $error("pullup enable wrong after config write");
  cload_code_a: assert property (atrim_wr_s |-> ##2
    cload_qpf_o == {1'b0, ~$past(req_i.wdata[5], 2), $past(req_i.wdata[4:0], 2)} + 7'h12)
    else $error("load capacitance wrong after trim write");
  cload_range_a: assert property (cload_qpf_o inside {[7'h10:7'h55]}) else $error("load capacitance out of range");
  halt_stop_a: assert property (count_halt_o |-> !sec_tick_o) else $error("second pulse while halted");
  halt_flag_a: assert property ($rose(count_halt_o) && !battery_mode_i |=> irq_oe_o)
    else $error("halt without event output");
  halt_release_a: assert property (time_write_i |=> !count_halt_o) else $error("halt kept after time write");
  halt_off_a: assert property (evcfg_wr_s and !req_i.wdata[7] |-> ##2 !count_halt_o)
    else $error("halt kept with detection off");
  tick_pulse_a: assert property (sec_tick_o |=> !sec_tick_o) else $error("second pulse longer than one cycle");
  sec_len_a: assert property (sec_tick_o && seen_ff |-> tick_cnt_ff inside {[17'h07FFC:17'h08004]})
    else $error("second length outside trim range");
endmodule

bind rtcev_top rtcev_top_sva rtcev_top_sva_inst (
  .sys_clk_i, .rst_n_i, .req_i, .time_write_i, .ts_tick_i, .sec_tick_o, .count_halt_o,
  .battery_mode_i, .irq_o, .irq_oe_o, .event_pullup_en_o, .cload_qpf_o);

// ==== tb/rtcev_top_tb.sv ====
// Self-checking bench for the event, alarm and trim control block.
// Assumes the clock model and the bound checker are compiled with it.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module rtcev_top_tb;
  logic                   sys_clk_i   = 1'b0;
  logic                   rst_n_i     = 1'b0;
  rtcev_pkg::rtcev_req_t  req         = '0;
  rtcev_pkg::rtcev_time_t ld_val      = '0;
  rtcev_pkg::rtcev_time_t tim;
  logic                   ld          = 1'b0;
  logic                   tw          = 1'b0;
  logic                   ev          = 1'b0;
  logic                   bat         = 1'b0;
  logic                   ts, sec, halt, irq, oe, pu;
  logic [7:0]             rd_d, v;
  logic [7:0]             lf          = 8'h13;
  logic [6:0]             cl;
  int                     errors      = 0;
  int                     check_count = 0;
  int                     n;

  rtcev_top #(.DEB1_CYC(8), .DEB2_CYC(16), .DEB3_CYC(32), .PULSE_CYC(64)) rtcev_top_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rd_d), .time_i(tim),
    .time_write_i(tw), .ts_tick_i(ts), .sec_tick_o(sec), .count_halt_o(halt), .event_input_i(ev),
    .battery_mode_i(bat), .irq_o(irq), .irq_oe_o(oe), .event_pullup_en_o(pu), .cload_qpf_o(cl));
  rtcev_clock_model rtcev_clock_model_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sec_tick_i(sec),
    .load_i(ld), .load_val_i(ld_val), .ts_tick_o(ts), .time_o(tim));

  always #10 sys_clk_i = ~sys_clk_i;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [6:0] exp_cl(input logic [7:0] a, input logic b);
    logic [6:0] o;
    o = {1'b0, ~a[5], a[4:0]} + 7'h12;
    if (b) begin
      case (a[7:6])
        2'h1: o = o - 7'h02;
        2'h2: o = o + 7'h02;
        2'h3: o = o + 7'h04;
        default: o = o;
      endcase
    end
    return o;
  endfunction

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task rd(input logic [4:0] a);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    req <= '0;
    #1;
    v = rd_d;
  endtask

  task settle(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask

  task ev_pulse(input int len);
    @(posedge sys_clk_i);
    ev <= 1'b1;
    repeat (len) @(posedge sys_clk_i);
    ev <= 1'b0;
    // Long enough for the slowest filter to drop back low
    settle(40);
  endtask

  task ld_time(input rtcev_pkg::rtcev_time_t t);
    @(posedge sys_clk_i);
    ld_val <= t;
    ld <= 1'b1;
    @(posedge sys_clk_i);
    ld <= 1'b0;
  endtask

  task wait_sec;
    n = 0;
    while (sec !== 1'b1 && n < 40000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 40000) begin
      errors++;
      complete_run();
    end
  endtask

  task complete_run;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle(2);
    `CHK(pu, 1'b1)
    `CHK(cl, 7'h32)
    for (int a = 12; a < 18; a++) begin
      rd(a[4:0]);
      `CHK(v, 8'h00)
      lf = lfsr(lf);
      wr(a[4:0], lf);
      rd(a[4:0]);
      `CHK(v, lf)
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      @(posedge sys_clk_i);
      bat <= i[2];
      settle(4);
      wr(rtcev_pkg::ADDR_ATRIM, {i[1:0], lf[5:0]});
      settle(2);
      `CHK(cl, exp_cl({i[1:0], lf[5:0]}, i[2]))
    end
    @(posedge sys_clk_i);
    bat <= 1'b0;
    wr(rtcev_pkg::ADDR_DTRIM, 8'h07);
    rd(rtcev_pkg::ADDR_DTRIM);
    `CHK(v[2:0], 3'h7)
    wr(rtcev_pkg::ADDR_EVCFG, 8'h41);
    settle(2);
    `CHK(pu, 1'b0)
    ld_time('{8'h12, 8'h34, 8'h09, 8'h21, 8'h05, 8'h24, 8'h03});
    ev_pulse(12);
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[3], 1'b0)
    `CHK(halt, 1'b0)
    wr(rtcev_pkg::ADDR_EVCFG, 8'hC0);
    ev_pulse(12);
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[3], 1'b1)
    `CHK(halt, 1'b1)
    `CHK(oe, 1'b1)
    for (int i = 0; i < 6; i++) begin
      rd(rtcev_pkg::ADDR_TS_LO + i[4:0]);
      `CHK(v, ld_val[55-8*i -: 8])
    end
    ld_time('{8'h40, 8'h34, 8'h09, 8'h21, 8'h05, 8'h24, 8'h03});
    ev_pulse(12);
    rd(rtcev_pkg::ADDR_TS_LO);
    `CHK(v, 8'h12)
    @(posedge sys_clk_i);
    tw <= 1'b1;
    @(posedge sys_clk_i);
    tw <= 1'b0;
    rd(rtcev_pkg::ADDR_EVCFG);
    `CHK(v[6], 1'b0)
    `CHK(halt, 1'b0)
    wr(rtcev_pkg::ADDR_STATUS, 8'h00);
    settle(2);
    `CHK(oe, 1'b0)
    for (int s = 1; s < 4; s++) begin
      wr(rtcev_pkg::ADDR_EVCFG, {2'h2, s[1:0], s[1:0], 2'h0});
      ev_pulse(2 << s);
      rd(rtcev_pkg::ADDR_STATUS);
      `CHK(v[3], 1'b0)
      ev_pulse((4 << s) + 4);
      rd(rtcev_pkg::ADDR_STATUS);
      `CHK(v[3], 1'b1)
      wr(rtcev_pkg::ADDR_STATUS, 8'h00);
    end
    wr(rtcev_pkg::ADDR_EVCFG, 8'h82);
    @(posedge sys_clk_i);
    bat <= 1'b1;
    ev_pulse(12);
    `CHK(oe, 1'b0)
    @(posedge sys_clk_i);
    bat <= 1'b0;
    settle(4);
    `CHK(oe, 1'b1)
    wr(rtcev_pkg::ADDR_STATUS, 8'h00);
    wr(rtcev_pkg::ADDR_EVCFG, 8'h00);
    for (int a = 13; a < 18; a++) wr(a[4:0], 8'h00);
    wr(rtcev_pkg::ADDR_ALM_LO, 8'h81);
    wr(rtcev_pkg::ADDR_INTCTL, 8'h40);
    ld_time('0);
    wait_sec();
    settle(6);
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[2], 1'b1)
    `CHK(oe, 1'b1)
    wr(rtcev_pkg::ADDR_STATUS, 8'h04);
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[2], 1'b1)
    wr(rtcev_pkg::ADDR_STATUS, 8'h00);
    settle(2);
    `CHK(oe, 1'b0)
    wr(rtcev_pkg::ADDR_ALM_LO, 8'h82);
    wr(rtcev_pkg::ADDR_INTCTL, 8'hC0);
    wr(rtcev_pkg::ADDR_STATUS, 8'h80);
    wait_sec();
    n = 0;
    repeat (100) begin
      @(posedge sys_clk_i);
      #1;
      if (oe === 1'b1) n++;
    end
    `CHK((n == 64 || n == 65), 1'b1)
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[2], 1'b1)
    rd(rtcev_pkg::ADDR_STATUS);
    `CHK(v[2], 1'b0)
    complete_run();
  end
endmodule
